// >>> rtl/rci_pkg.sv
package rci_pkg;
  // Register indices as printed; the byte address on the bus is four times the index.
  localparam logic [15:0] IDX_SYSTEM_CONTROL = 16'hFFF2;
  localparam logic [15:0] IDX_REQUEST_SENSE_CONTROL = 16'hFFF4;
  localparam logic [15:0] IDX_REQUEST_ENABLE = 16'hFFF5;
  localparam logic [15:0] IDX_REQUEST_FLAGS = 16'hFFF6;
  localparam logic [15:0] IDX_PRIORITY_LEVEL_A = 16'hFFF8;
  localparam logic [15:0] IDX_PRIORITY_LEVEL_B = 16'hFFF9;
  localparam int unsigned MIN_ADDR_W = 18;

  localparam logic [7:0] RST_SYSTEM_CONTROL = 8'h0B;
  localparam logic [7:0] RST_REQUEST_SENSE_CONTROL = 8'h00;
  localparam logic [7:0] RST_REQUEST_ENABLE = 8'h00;
  localparam logic [7:0] RST_REQUEST_FLAGS = 8'h00;
  localparam logic [7:0] RST_PRIORITY_LEVEL_A = 8'h00;
  localparam logic [7:0] RST_PRIORITY_LEVEL_B = 8'h00;

  localparam int unsigned USER_BIT_SELECT_POS = 3;
  localparam int unsigned NONMASKABLE_EDGE_SELECT_POS = 2;
  localparam int unsigned CCR_MASK_POS = 7;
  localparam int unsigned CCR_USER_MASK_POS = 6;

  localparam int unsigned N_EXT = 6;
  localparam int unsigned N_INT = 30;
  localparam int unsigned N_SRC = N_EXT + N_INT;

  localparam logic [5:0] VEC_RESET = 6'h00;
  localparam logic [5:0] VEC_NMI = 6'h07;
  localparam logic [5:0] VEC_TRAP_BASE = 6'h08;
  localparam logic [5:0] VEC_EXT_BASE = 6'h0C;
  localparam logic [5:0] VEC_INT_BASE = 6'h14;

  // Clock cycles the chip stays in reset after a watchdog overflow.
  localparam logic [3:0] WDT_RESET_CYCLES = 4'hA;
  // Least low time of the reset pin during operation, in system clock cycles.
  localparam int unsigned RES_MIN_LOW_CYCLES = 10;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    S_RESET, S_RV_HI, S_RV_LO, S_FIRST, S_RUN, S_PUSH_LO, S_PUSH_HI, S_VEC_HI, S_VEC_LO, S_LOAD
  } rci_state_e;
endpackage

// >>> rtl/rci_top.sv
module rci_top
  import rci_pkg::*;
#(
  parameter int unsigned ADDR_W = 18
) (
  // Clock and power-on reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Chip pins
  input wire logic chip_reset_input_n,
  input wire logic hw_standby_n,
  input wire logic nmi_pin,
  input wire logic [N_EXT-1:0] external_request_lines_n,
  // On-chip modules
  input wire logic watchdog_overflow,
  input wire logic [N_INT-1:0] module_req,
  // CPU core
  input wire logic cpu_boundary,
  input wire logic trap_req,
  input wire logic [1:0] trap_num,
  input wire logic [23:0] cpu_pc,
  input wire logic [7:0] cpu_ccr,
  input wire logic [23:0] cpu_sp,
  output logic cpu_halt,
  output logic cpu_load,
  output logic cpu_load_sp,
  output logic [23:0] new_pc,
  output logic [7:0] new_ccr,
  output logic [23:0] new_sp,
  output logic [5:0] exc_vector,
  // Exception memory port
  output logic mem_req,
  output logic mem_we,
  output logic [23:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  if (ADDR_W < MIN_ADDR_W) begin : g_addr_check
    $error("ADDR_W too narrow for the register map");
  end

  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] b;
    b = a & ~ADDR_W'(3);
    if (b == ADDR_W'({IDX_SYSTEM_CONTROL, 2'b00})) return 3'h1;
    else if (b == ADDR_W'({IDX_REQUEST_SENSE_CONTROL, 2'b00})) return 3'h2;
    else if (b == ADDR_W'({IDX_REQUEST_ENABLE, 2'b00})) return 3'h3;
    else if (b == ADDR_W'({IDX_REQUEST_FLAGS, 2'b00})) return 3'h4;
    else if (b == ADDR_W'({IDX_PRIORITY_LEVEL_A, 2'b00})) return 3'h5;
    else if (b == ADDR_W'({IDX_PRIORITY_LEVEL_B, 2'b00})) return 3'h6;
    else return 3'h0;
  endfunction

  function automatic logic [23:0] word_addr(input logic [23:0] a);
    return {a[23:1], 1'b0};
  endfunction

  // Two-flop synchronisers for pins; the third stage only feeds edge detection.
  logic res_s1_q, res_s2_q, stby_s1_q, stby_s2_q, nmi_s1_q, nmi_s2_q, nmi_s3_q;
  logic [N_EXT-1:0] irq_s1_q, irq_s2_q, irq_s3_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_s1_q <= 1'b0;
      res_s2_q <= 1'b0;
      stby_s1_q <= 1'b0;
      stby_s2_q <= 1'b0;
      nmi_s1_q <= 1'b0;
      nmi_s2_q <= 1'b0;
      nmi_s3_q <= 1'b0;
      irq_s1_q <= '1;
      irq_s2_q <= '1;
      irq_s3_q <= '1;
    end else begin
      res_s1_q <= chip_reset_input_n;
      res_s2_q <= res_s1_q;
      stby_s1_q <= hw_standby_n;
      stby_s2_q <= stby_s1_q;
      nmi_s1_q <= nmi_pin;
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
      irq_s1_q <= external_request_lines_n;
      irq_s2_q <= irq_s1_q;
      irq_s3_q <= irq_s2_q;
    end
  end

  // Chip reset: pin low or a stretched watchdog overflow; standby only initialises the registers.
  logic [3:0] wdt_cnt_q, wdt_cnt_d;
  logic chip_rst, regs_init;
  always_comb begin
    wdt_cnt_d = wdt_cnt_q;
    if (watchdog_overflow) wdt_cnt_d = WDT_RESET_CYCLES;
    else if (wdt_cnt_q != 4'h0) wdt_cnt_d = wdt_cnt_q - 4'h1;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) wdt_cnt_q <= 4'h0;
    else wdt_cnt_q <= wdt_cnt_d;
  end
  assign chip_rst = !res_s2_q || (wdt_cnt_q != 4'h0) || watchdog_overflow;
  assign regs_init = chip_rst || !stby_s2_q;

  // Register file and AXI4-Lite slave.
  logic [7:0] sysctl_q, sysctl_d, sense_q, sense_d, enable_q, enable_d;
  logic [7:0] prio_a_q, prio_a_d, prio_b_q, prio_b_d;
  logic [N_EXT-1:0] flags_q, flags_d, flag_set;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic wstb_q, wstb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic aw_ok, w_ok, do_write, wr_stb;
  logic [2:0] wsel, rsel;
  logic [ADDR_W-1:0] wa;
  logic [7:0] wb;
  logic nmi_edge;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign aw_ok = aw_have_q || (s_axi_awvalid && s_axi_awready);
  assign w_ok = w_have_q || (s_axi_wvalid && s_axi_wready);
  assign do_write = aw_ok && w_ok && !bvalid_q;
  assign wa = aw_have_q ? awaddr_q : s_axi_awaddr;
  assign wb = w_have_q ? wbyte_q : s_axi_wdata[7:0];
  assign wr_stb = w_have_q ? wstb_q : s_axi_wstrb[0];
  assign wsel = reg_sel(wa);
  assign rsel = reg_sel(s_axi_araddr);

  // Falling edge or low level per line, set by the sense control bit.
  assign flag_set = (sense_q[N_EXT-1:0] & irq_s3_q & ~irq_s2_q)
                  | (~sense_q[N_EXT-1:0] & ~irq_s2_q);

  always_comb begin
    sysctl_d = sysctl_q;
    sense_d = sense_q;
    enable_d = enable_q;
    prio_a_d = prio_a_q;
    prio_b_d = prio_b_q;
    flags_d = flags_q;
    aw_have_d = aw_have_q && !do_write;
    w_have_d = w_have_q && !do_write;
    awaddr_d = awaddr_q;
    wbyte_d = wbyte_q;
    wstb_d = wstb_q;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && s_axi_awready && !do_write) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready && !do_write) begin
      w_have_d = 1'b1;
      wbyte_d = s_axi_wdata[7:0];
      wstb_d = s_axi_wstrb[0];
    end
    if (do_write) begin
      bvalid_d = 1'b1;
      bresp_d = (wsel == 3'h0) ? AXI_SLVERR : AXI_OKAY;
      if (wr_stb) begin
        case (wsel)
          3'h1: sysctl_d = wb;
          3'h2: sense_d = wb;
          3'h3: enable_d = wb;
          3'h4: flags_d = flags_q & wb[N_EXT-1:0];
          3'h5: prio_a_d = wb;
          3'h6: prio_b_d = wb;
          default: ;
        endcase
      end
    end
    // Hardware set wins over a clearing write in the same cycle.
    flags_d = flags_d | flag_set;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = (rsel == 3'h0) ? AXI_SLVERR : AXI_OKAY;
      case (rsel)
        3'h1: rdata_d = {24'h0, sysctl_q};
        3'h2: rdata_d = {24'h0, sense_q};
        3'h3: rdata_d = {24'h0, enable_q};
        3'h4: rdata_d = {26'h0, flags_q};
        3'h5: rdata_d = {24'h0, prio_a_q};
        3'h6: rdata_d = {24'h0, prio_b_q};
        default: rdata_d = 32'h0;
      endcase
    end
    if (regs_init) begin
      sysctl_d = RST_SYSTEM_CONTROL;
      sense_d = RST_REQUEST_SENSE_CONTROL;
      enable_d = RST_REQUEST_ENABLE;
      flags_d = RST_REQUEST_FLAGS[N_EXT-1:0];
      prio_a_d = RST_PRIORITY_LEVEL_A;
      prio_b_d = RST_PRIORITY_LEVEL_B;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sysctl_q <= RST_SYSTEM_CONTROL;
      sense_q <= RST_REQUEST_SENSE_CONTROL;
      enable_q <= RST_REQUEST_ENABLE;
      flags_q <= RST_REQUEST_FLAGS[N_EXT-1:0];
      prio_a_q <= RST_PRIORITY_LEVEL_A;
      prio_b_q <= RST_PRIORITY_LEVEL_B;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= 8'h00;
      wstb_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= AXI_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= AXI_OKAY;
      rdata_q <= 32'h0;
    end else begin
      sysctl_q <= sysctl_d;
      sense_q <= sense_d;
      enable_q <= enable_d;
      flags_q <= flags_d;
      prio_a_q <= prio_a_d;
      prio_b_q <= prio_b_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wbyte_q <= wbyte_d;
      wstb_q <= wstb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Arbitration: index 0-5 are the external lines, 6-35 the module requests.
  logic [N_SRC-1:0] src_req, src_hi;
  logic found_hi, found_lo, allow_hi, allow_lo, take_nmi, take_int, ue;
  logic [5:0] idx_hi, idx_lo, pick_vec;

  function automatic logic [N_SRC-1:0] level_map(input logic [7:0] pa, input logic [7:0] pb);
    logic [N_SRC-1:0] m;
    m = {pb[1], {4{pb[2]}}, {4{pb[3]}}, {4{pb[5]}}, {3{pb[6]}}, {3{pb[7]}},
         {3{pa[0]}}, {3{pa[1]}}, {3{pa[2]}}, {2{pa[3]}}, {2{pa[4]}}, {2{pa[5]}}, pa[6], pa[7]};
    return m;
  endfunction

  assign src_req = {module_req, flags_q & enable_q[N_EXT-1:0]};
  assign src_hi = level_map(prio_a_q, prio_b_q);
  assign ue = sysctl_q[USER_BIT_SELECT_POS];
  // Three mask levels; with user bit select set, the user mask bit is ignored.
  assign allow_lo = !cpu_ccr[CCR_MASK_POS];
  assign allow_hi = !cpu_ccr[CCR_MASK_POS] || (!ue && !cpu_ccr[CCR_USER_MASK_POS]);

  always_comb begin
    found_hi = 1'b0;
    found_lo = 1'b0;
    idx_hi = 6'h0;
    idx_lo = 6'h0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (src_req[i] && src_hi[i]) begin
        found_hi = 1'b1;
        idx_hi = 6'(i);
      end
      if (src_req[i] && !src_hi[i]) begin
        found_lo = 1'b1;
        idx_lo = 6'(i);
      end
    end
  end

  logic nmi_pend_q, nmi_pend_d;
  rci_state_e state_q, state_d;
  logic [5:0] sel_idx;
  assign sel_idx = (found_hi && allow_hi) ? idx_hi : idx_lo;
  assign nmi_edge = sysctl_q[NONMASKABLE_EDGE_SELECT_POS] ? (nmi_s2_q && !nmi_s3_q)
                                                          : (!nmi_s2_q && nmi_s3_q);
  assign take_nmi = nmi_pend_q && (state_q == S_RUN) && cpu_boundary;
  assign take_int = (state_q == S_RUN) && cpu_boundary &&
                    (nmi_pend_q || (found_hi && allow_hi) || (found_lo && allow_lo));
  assign pick_vec = nmi_pend_q ? VEC_NMI :
                    (sel_idx < 6'(N_EXT)) ? VEC_EXT_BASE + sel_idx
                                          : VEC_INT_BASE + sel_idx - 6'(N_EXT);

  // Edges are discarded until the first instruction has run.
  always_comb begin
    nmi_pend_d = nmi_pend_q;
    if (take_nmi) nmi_pend_d = 1'b0;
    if (nmi_edge) nmi_pend_d = 1'b1;
    if (chip_rst || state_q == S_RV_HI || state_q == S_RV_LO || state_q == S_FIRST) begin
      nmi_pend_d = 1'b0;
    end
  end

  // Exception sequencer.
  logic mem_req_q, mem_req_d, mem_we_q, mem_we_d, load_q, load_d, load_sp_q, load_sp_d;
  logic [23:0] mem_addr_q, mem_addr_d, pc_q, pc_d, sp_q, sp_d;
  logic [15:0] wdata_q, wdata_d;
  logic [7:0] ccr_q, ccr_d;
  logic [5:0] vec_q, vec_d;
  logic [23:0] frame_pc_q, frame_pc_d;
  logic [7:0] frame_ccr_q, frame_ccr_d;

  always_comb begin
    state_d = state_q;
    mem_req_d = mem_req_q && !mem_ack;
    mem_we_d = mem_we_q;
    mem_addr_d = mem_addr_q;
    wdata_d = wdata_q;
    load_d = 1'b0;
    load_sp_d = load_sp_q;
    pc_d = pc_q;
    sp_d = sp_q;
    ccr_d = ccr_q;
    vec_d = vec_q;
    frame_pc_d = frame_pc_q;
    frame_ccr_d = frame_ccr_q;
    case (state_q)
      S_RESET: if (!chip_rst) begin
        state_d = S_RV_HI;
        vec_d = VEC_RESET;
        ccr_d = 8'h00;
        ccr_d[CCR_MASK_POS] = 1'b1;
        load_sp_d = 1'b0;
        mem_req_d = 1'b1;
        mem_we_d = 1'b0;
        mem_addr_d = 24'h000000;
      end
      S_RV_HI, S_VEC_HI: if (mem_ack) begin
        pc_d = {mem_rdata[7:0], 16'h0000};
        state_d = (state_q == S_RV_HI) ? S_RV_LO : S_VEC_LO;
        mem_req_d = 1'b1;
        mem_addr_d = word_addr(mem_addr_q + 24'h2);
      end
      S_RV_LO, S_VEC_LO: if (mem_ack) begin
        pc_d = {pc_q[23:16], mem_rdata};
        load_d = 1'b1;
        state_d = (state_q == S_RV_LO) ? S_FIRST : S_RUN;
      end
      S_FIRST: if (cpu_boundary) state_d = S_RUN;
      S_RUN: if (take_int || (cpu_boundary && trap_req)) begin
        frame_pc_d = cpu_pc;
        frame_ccr_d = cpu_ccr;
        ccr_d = cpu_ccr;
        ccr_d[CCR_MASK_POS] = 1'b1;
        if (!ue) ccr_d[CCR_USER_MASK_POS] = 1'b1;
        vec_d = take_int ? pick_vec : VEC_TRAP_BASE + {4'h0, trap_num};
        sp_d = word_addr(cpu_sp - 24'h4);
        load_sp_d = 1'b1;
        state_d = S_PUSH_LO;
        mem_req_d = 1'b1;
        mem_we_d = 1'b1;
        mem_addr_d = word_addr(cpu_sp - 24'h2);
        wdata_d = cpu_pc[15:0];
      end
      S_PUSH_LO: if (mem_ack) begin
        state_d = S_PUSH_HI;
        mem_req_d = 1'b1;
        mem_addr_d = sp_q;
        wdata_d = {frame_ccr_q, frame_pc_q[23:16]};
      end
      S_PUSH_HI: if (mem_ack) begin
        state_d = S_VEC_HI;
        mem_req_d = 1'b1;
        mem_we_d = 1'b0;
        mem_addr_d = {16'h0000, vec_q, 2'b00};
      end
      default: state_d = S_RESET;
    endcase
    if (chip_rst) begin
      state_d = S_RESET;
      mem_req_d = 1'b0;
      mem_we_d = 1'b0;
      load_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_RESET;
      nmi_pend_q <= 1'b0;
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= 24'h0;
      wdata_q <= 16'h0;
      load_q <= 1'b0;
      load_sp_q <= 1'b0;
      pc_q <= 24'h0;
      sp_q <= 24'h0;
      ccr_q <= 8'h80;
      vec_q <= VEC_RESET;
      frame_pc_q <= 24'h0;
      frame_ccr_q <= 8'h00;
    end else begin
      state_q <= state_d;
      nmi_pend_q <= nmi_pend_d;
      mem_req_q <= mem_req_d;
      mem_we_q <= mem_we_d;
      mem_addr_q <= mem_addr_d;
      wdata_q <= wdata_d;
      load_q <= load_d;
      load_sp_q <= load_sp_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      ccr_q <= ccr_d;
      vec_q <= vec_d;
      frame_pc_q <= frame_pc_d;
      frame_ccr_q <= frame_ccr_d;
    end
  end

  assign cpu_halt = (state_q != S_RUN) && (state_q != S_FIRST);
  assign cpu_load = load_q;
  assign cpu_load_sp = load_sp_q;
  assign new_pc = pc_q;
  assign new_ccr = ccr_q;
  assign new_sp = sp_q;
  assign exc_vector = vec_q;
  assign mem_req = mem_req_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = wdata_q;

  chk_halt_in_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    chip_rst |=> cpu_halt && !mem_req) else $error("not halted in reset");
  chk_release_fetch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(res_s2_q) && wdt_cnt_q == 4'h0 && !watchdog_overflow && stby_s2_q
    |=> mem_req && mem_addr == 24'h0 && !mem_we) else $error("no reset fetch");
  chk_wdt_resets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    watchdog_overflow |=> state_q == S_RESET [*8]) else $error("watchdog reset short");
  chk_reset_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == S_RV_LO && mem_ack && !chip_rst |=> cpu_load && new_ccr[CCR_MASK_POS]
    && !cpu_load_sp && exc_vector == VEC_RESET) else $error("reset load wrong");
  chk_first_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == S_FIRST |-> !take_int && !nmi_pend_q) else $error("interrupt before first");
  chk_nmi_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take_nmi && !chip_rst |=> exc_vector == VEC_NMI && state_q == S_PUSH_LO) else
    $error("nmi not taken");
  chk_mask_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take_int && cpu_ccr[CCR_MASK_POS] && (ue || cpu_ccr[CCR_USER_MASK_POS]) |-> nmi_pend_q)
    else $error("masked request taken");
  chk_trap_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == S_RUN && cpu_boundary && trap_req && !take_int && !chip_rst |=>
    new_ccr[CCR_MASK_POS] && new_ccr[CCR_USER_MASK_POS] == (!$past(ue) ||
    $past(cpu_ccr[CCR_USER_MASK_POS])) && exc_vector == VEC_TRAP_BASE + {4'h0, $past(trap_num)})
    else $error("trap entry wrong");
  chk_word_even: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mem_req |-> !mem_addr[0]) else $error("odd word address");
  chk_sysctl_init: assert property (@(posedge ref_clk) disable iff (!rst_n)
    regs_init |=> sysctl_q == RST_SYSTEM_CONTROL && flags_q == '0) else
    $error("registers not initialised");

  cov_reset_done: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == S_FIRST ##[1:50] state_q == S_RUN);
  cov_nmi: cover property (@(posedge ref_clk) disable iff (!rst_n) take_nmi);
  cov_trap: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == S_RUN && cpu_boundary && trap_req && !take_int);
  cov_hi_over_lo: cover property (@(posedge ref_clk) disable iff (!rst_n)
    take_int && found_hi && found_lo && !nmi_pend_q);
endmodule

// >>> testbench/rci_mem_model.sv
module rci_mem_model (
  // Exception memory port
  input wire logic ref_clk,
  input wire logic mem_req,
  input wire logic [23:0] mem_addr,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_q = 2'h0;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 16'h0;
  end
  // Every access gets the same single wait cycle before its ack, and data is valid only with the ack.
  always @(posedge ref_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      cnt_q <= cnt_q + 2'h1;
      if (cnt_q[0]) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem_addr[15:0] ^ 16'hA5C3;
      end
    end
  end
endmodule

// >>> testbench/tb_reset_and_interrupt_control.sv
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb_reset_and_interrupt_control;
  import rci_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst_n = 0, chip_reset_input_n = 1, hw_standby_n = 1, nmi_pin = 0;
  logic [5:0] external_request_lines_n = 6'h3F;
  logic watchdog_overflow = 0, cpu_boundary = 0, trap_req = 0, mem_ack, mem_req, mem_we;
  logic [29:0] module_req = 30'h0;
  logic [1:0] trap_num = 2'h0, s_axi_bresp, s_axi_rresp, rs;
  logic [23:0] cpu_pc = 24'h0, cpu_sp = 24'h100, new_pc, new_sp, mem_addr;
  logic [23:0] pc_seen = 24'h0;
  logic [7:0] cpu_ccr = 8'h80, new_ccr, r = 8'h1F;
  logic cpu_halt, cpu_load, cpu_load_sp, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arready, s_axi_rvalid;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [5:0] exc_vector;
  logic [15:0] mem_wdata, mem_rdata;
  logic [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  int checked = 0, fail_count = 0, cyc = 0;
  rci_top uut (.*);
  rci_mem_model mem (.*);
  initial forever #50 ref_clk = ~ref_clk;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [23:0] vec_pc(input logic [15:0] a);
    logic [15:0] h;
    h = a ^ 16'hA5C3;
    return {h[7:0], (a + 16'h2) ^ 16'hA5C3};
  endfunction
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Random module requests stay held off: the mask bit is set in cpu_ccr and both priority level registers keep every source at the low level.
  always @(posedge ref_clk) begin
    r <= lfsr(r);
    module_req <= {r[5:0], r, r, r};
    cpu_pc <= {r, ~r, r};
    cyc++;
    if (mem_req && mem_addr[0]) `CHK("addr_bit0", 1'b0, mem_addr[0])
    // The frame pushed on entry must hold the PC seen at the taking boundary.
    if (cpu_boundary) pc_seen <= cpu_pc;
    if (mem_req && mem_we && mem_ack)
      `CHK("push", mem_addr == new_sp ? {cpu_ccr, pc_seen[23:16]} : pc_seen[15:0], mem_wdata)
    if (cyc == 3000) begin
      fail_count++;
      print_verdict;
    end
  end
  task automatic axi_wr(input logic [15:0] idx, input logic [7:0] v);
    logic b;
    b = 0;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!b) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) begin
        b = 1;
        s_axi_bready <= 0;
      end
    end
  endtask
  task automatic axi_rd(input logic [15:0] idx);
    logic b;
    b = 0;
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!b) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) begin
        b = 1;
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 0;
      end
    end
  endtask
  task automatic wait_load(input logic [15:0] a, input logic sp);
    int n;
    n = 0;
    while (cpu_load !== 1'b1 && n < 60) begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("cpu_load", 1'b1, cpu_load)
    `CHK("new_pc", vec_pc(a), new_pc)
    `CHK("mask_bit", 1'b1, new_ccr[7])
    `CHK("load_sp", sp, cpu_load_sp)
  endtask
  task automatic bnd(input logic t);
    cpu_boundary <= 1;
    trap_req <= t;
    @(posedge ref_clk);
    cpu_boundary <= 0;
    trap_req <= 0;
    @(posedge ref_clk);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1;
    wait_load(16'h0, 1'b0);
    axi_rd(IDX_SYSTEM_CONTROL);
    `CHK("system_control", 32'h0B, d)
    axi_rd(16'hFFF0);
    `CHK("unmapped", AXI_SLVERR, rs)
    axi_wr(IDX_REQUEST_FLAGS, 8'hFF);
    axi_rd(IDX_REQUEST_FLAGS);
    `CHK("request_flags", 32'h0, d)
    bnd(1'b0);
    for (int k = 0; k < 4; k++) begin
      axi_wr(IDX_SYSTEM_CONTROL, k[0] ? 8'h03 : 8'h0B);
      trap_num <= r[1:0];
      cpu_sp <= {8'h0, r, 8'h40};
      @(posedge ref_clk);
      bnd(1'b1);
      wait_load({trap_num, 2'h0} + 16'h20, 1'b1);
      `CHK("exc_vector", VEC_TRAP_BASE + trap_num, exc_vector)
      `CHK("user_mask", k[0], new_ccr[6])
      `CHK("new_sp", cpu_sp - 24'h4, new_sp)
    end
    chip_reset_input_n <= 0;
    repeat (12) @(posedge ref_clk);
    `CHK("halt", 1'b1, cpu_halt)
    `CHK("no_fetch", 1'b0, mem_req)
    chip_reset_input_n <= 1;
    wait_load(16'h0, 1'b0);
    axi_rd(IDX_SYSTEM_CONTROL);
    `CHK("system_control", 32'h0B, d)
    watchdog_overflow <= 1;
    @(posedge ref_clk);
    watchdog_overflow <= 0;
    repeat (3) @(posedge ref_clk);
    `CHK("halt", 1'b1, cpu_halt)
    wait_load(16'h0, 1'b0);
    bnd(1'b0);
    // A rising edge is ignored with the default falling-edge select.
    nmi_pin <= 1;
    repeat (4) @(posedge ref_clk);
    nmi_pin <= 0;
    repeat (4) @(posedge ref_clk);
    bnd(1'b0);
    wait_load(16'h1C, 1'b1);
    `CHK("exc_vector", VEC_NMI, exc_vector)
    print_verdict;
  end
endmodule
